// >>> shared/rlc_pkg.sv
/*
  Package of the redriver link control register bank: offsets, field
  positions, reset values, mode codes and cycle counts.
  Assumes a 20 MHz register clock.
*/
package rlc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] RLC_ADDR_UPSTREAM_EQ = 8'h21;
  localparam logic [7:0] RLC_ADDR_LINK_CTRL   = 8'h22;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RLC_UPSTREAM_EQ_RST = 8'h00;
  localparam logic [7:0] RLC_LINK_CTRL_RST   = 8'h00;

  // ==========================================================
  // Field positions of the equalization and link control registers
  localparam int RLC_EQ_LSB        = 0;
  localparam int RLC_EQ_W          = 4;
  localparam int RLC_FORCE_LSB     = 0;
  localparam int RLC_PERIOD_LSB    = 2;
  localparam int RLC_DETECT_OFF    = 4;
  localparam int RLC_DEBOUNCE_BIT  = 5;
  localparam int RLC_KEEP_EQ_BIT   = 6;
  localparam int RLC_STATUS_BIT    = 7;

  // ==========================================================
  // Mode codes
  typedef enum logic [1:0] {
    RLC_FORCE_FSM        = 2'h0,
    RLC_FORCE_DOWNSTREAM = 2'h1,
    RLC_FORCE_UPSTREAM   = 2'h2,
    RLC_FORCE_NEVER      = 2'h3
  } rlc_force_t;

  typedef enum logic [1:0] {
    RLC_PERIOD_8MS  = 2'h0,
    RLC_PERIOD_12MS = 2'h1
  } rlc_period_t;

  // ==========================================================
  // Timing
  localparam int RLC_CLK_PERIOD_NS = 50;
  localparam int RLC_DEBOUNCE_US   = 200;
  localparam int RLC_PERIOD_A_MS   = 8;
  localparam int RLC_PERIOD_B_MS   = 12;
  localparam int RLC_TMR_W         = 18;
  localparam int RLC_DEBOUNCE_CYC  =
    (RLC_DEBOUNCE_US * 1000 + RLC_CLK_PERIOD_NS - 1) / RLC_CLK_PERIOD_NS;
  localparam int RLC_PERIOD_A_CYC  =
    (RLC_PERIOD_A_MS * 1000000) / RLC_CLK_PERIOD_NS;
  localparam int RLC_PERIOD_B_CYC  =
    (RLC_PERIOD_B_MS * 1000000) / RLC_CLK_PERIOD_NS;

endpackage

// >>> shared/rlc_timer_if.sv
/*
  Interface between the control bank and its interval timers.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface rlc_timer_if;
  import rlc_pkg::*;

  logic                 run;
  logic [RLC_TMR_W-1:0] limit;
  logic                 expired;

  modport ctrl (output run, output limit, input expired);
  modport tmr  (input run, input limit, output expired);
endinterface

// >>> design/rlc_timer.sv
/*
  Interval timer: counts while run is high and pulses expired every
  limit cycles; clears at once when run drops.
  Assumes limit is at least 1 and steady while running.
*/
`timescale 1ns/1ps
module rlc_timer
  import rlc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  rlc_timer_if.tmr  tmr_if
);

  logic [RLC_TMR_W-1:0] count_reg;
  logic [RLC_TMR_W-1:0] count_next;
  logic                 expired_reg;
  logic                 at_end;

  // ==========================================================
  // Counting
  assign at_end     = (count_reg == tmr_if.limit - 18'h00001);
  assign count_next = (!tmr_if.run || at_end) ? '0
                                              : count_reg + 18'h00001;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      count_reg   <= '0;
      expired_reg <= 1'b0;
    end
    else
    begin
      count_reg   <= count_next;
      expired_reg <= tmr_if.run && at_end;
    end
  end

  assign tmr_if.expired = expired_reg;

endmodule // rlc_timer

// >>> design/rlc_link_ctrl.sv
/*
  Link control register bank of the redriver: upstream receiver
  equalization (0x21) and link power / compliance control (0x22).
  Assumes a register port on clk_in and analog/FSM status inputs;
  the equalization source bit lives in the general register elsewhere.

*/
`timescale 1ns/1ps
module rlc_link_ctrl
  import rlc_pkg::*;
#(
  parameter logic [RLC_TMR_W-1:0] PERIOD_A_CYC =
    RLC_TMR_W'(RLC_PERIOD_A_CYC),
  parameter logic [RLC_TMR_W-1:0] PERIOD_B_CYC =
    RLC_TMR_W'(RLC_PERIOD_B_CYC)
)
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_write_in,
  input  wire logic       reg_read_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       eq_source_software_in,
  input  wire logic [1:0] upstream_eq_straps_in,
  input  wire logic [3:0] first_rx_eq_level_in,
  input  wire logic [3:0] second_rx_eq_level_in,
  input  wire logic       lfps_detect_in,
  input  wire logic       low_power_state_in,
  input  wire logic       fsm_compliance_req_in,
  output logic      [3:0] upstream_eq_applied_out,
  output logic      [3:0] first_eq_applied_out,
  output logic      [3:0] second_eq_applied_out,
  output logic            low_power_exit_out,
  output logic            rx_detect_pulse_out,
  output logic            compliance_downstream_out,
  output logic            compliance_upstream_out
);

  // ==========================================================
  // Declarations
  logic [1:0] strap_meta_reg;
  logic [1:0] strap_sync_reg;
  logic       lfps_meta_reg;
  logic       lfps_sync_reg;
  logic       strap_taken_reg;
  logic [1:0] strap_latched_reg;
  logic [3:0] sw_eq_reg;
  logic [3:0] sw_eq_next;
  logic       keep_eq_reg;
  logic       debounce_reg;
  logic       detect_off_reg;
  logic [1:0] period_reg;
  logic [1:0] force_reg;
  logic       status_reg;
  logic       status_next;
  logic       exit_done_reg;
  logic [7:0] rdata_reg;
  logic [3:0] up_eq_reg;
  logic [3:0] first_eq_reg;
  logic [3:0] second_eq_reg;
  logic       down_reg;
  logic       up_reg;
  logic       down_next;
  logic       up_next;

  wire        hit_eq   = (reg_addr_in == RLC_ADDR_UPSTREAM_EQ);
  wire        hit_ctrl = (reg_addr_in == RLC_ADDR_LINK_CTRL);
  wire        wr_eq    = reg_write_in && hit_eq;
  wire        wr_ctrl  = reg_write_in && hit_ctrl;
  wire [3:0]  strap_eq = {2'h0, strap_latched_reg};
  wire [3:0]  field_eq;
  wire [7:0]  eq_word;
  wire [7:0]  ctrl_word;
  wire [7:0]  rdata_next;
  wire        zero_eq;
  wire        lfps_exit_now;

  rlc_timer_if debounce_if ();
  rlc_timer_if period_if ();

  // ==========================================================
  // Pin synchronisers and strap capture
  // Strap stages run through reset, so the first capture after
  // release already sees the settled pins
  always_ff @(posedge clk_in)
  begin
    strap_meta_reg <= upstream_eq_straps_in;
    strap_sync_reg <= strap_meta_reg;
  end

  // Straps are caught once, after reset release, never while held
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      lfps_meta_reg     <= 1'b0;
      lfps_sync_reg     <= 1'b0;
      strap_taken_reg   <= 1'b0;
      strap_latched_reg <= 2'h0;
    end
    else
    begin
      lfps_meta_reg   <= lfps_detect_in;
      lfps_sync_reg   <= lfps_meta_reg;
      strap_taken_reg <= 1'b1;
      if (!strap_taken_reg)
        strap_latched_reg <= strap_sync_reg;
    end
  end

  // ==========================================================
  // Equalization selection
  // Straps must stand steady two cycles before reset release
  assign sw_eq_next = wr_eq ? reg_wdata_in[RLC_EQ_LSB +: RLC_EQ_W]
                            : sw_eq_reg;
  assign field_eq   = eq_source_software_in ? sw_eq_reg
                                            : strap_eq;
  assign zero_eq    = lfps_sync_reg && !keep_eq_reg;

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sw_eq_reg      <= RLC_UPSTREAM_EQ_RST[RLC_EQ_LSB +: RLC_EQ_W];
      keep_eq_reg    <= RLC_LINK_CTRL_RST[RLC_KEEP_EQ_BIT];
      debounce_reg   <= RLC_LINK_CTRL_RST[RLC_DEBOUNCE_BIT];
      detect_off_reg <= RLC_LINK_CTRL_RST[RLC_DETECT_OFF];
      period_reg     <= RLC_LINK_CTRL_RST[RLC_PERIOD_LSB +: 2];
      force_reg      <= RLC_LINK_CTRL_RST[RLC_FORCE_LSB +: 2];
    end
    else
    begin
      sw_eq_reg <= sw_eq_next;
      if (wr_ctrl)
      begin
        keep_eq_reg    <= reg_wdata_in[RLC_KEEP_EQ_BIT];
        debounce_reg   <= reg_wdata_in[RLC_DEBOUNCE_BIT];
        detect_off_reg <= reg_wdata_in[RLC_DETECT_OFF];
        period_reg     <= reg_wdata_in[RLC_PERIOD_LSB +: 2];
        force_reg      <= reg_wdata_in[RLC_FORCE_LSB +: 2];
      end
    end
  end

  // ==========================================================
  // Compliance forcing
  always_comb
  begin
    down_next = 1'b0;
    up_next   = 1'b0;
    case (rlc_force_t'(force_reg))
      RLC_FORCE_FSM:
      begin
        down_next = fsm_compliance_req_in;
        up_next   = fsm_compliance_req_in;
      end
      RLC_FORCE_DOWNSTREAM: down_next = 1'b1;
      RLC_FORCE_UPSTREAM:   up_next   = 1'b1;
      RLC_FORCE_NEVER:
      begin
        down_next = 1'b0;
        up_next   = 1'b0;
      end
      default:
      begin
        down_next = 1'b0;
        up_next   = 1'b0;
      end
    endcase
  end

  assign status_next = down_next || up_next;

  // ==========================================================
  // Low-power exit and receiver detect timers
  assign debounce_if.run   = lfps_sync_reg && low_power_state_in
                             && debounce_reg && !exit_done_reg;
  assign debounce_if.limit = RLC_TMR_W'(RLC_DEBOUNCE_CYC);
  assign lfps_exit_now     = debounce_reg ? debounce_if.expired
                           : (lfps_sync_reg && low_power_state_in
                              && !exit_done_reg);

  // Reserved period codes fall back to the shorter interval
  assign period_if.run   = !(low_power_state_in && detect_off_reg);
  assign period_if.limit =
    (rlc_period_t'(period_reg) == RLC_PERIOD_12MS) ? PERIOD_B_CYC
                                                   : PERIOD_A_CYC;

  rlc_timer u_debounce (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .tmr_if   (debounce_if.tmr)
  );

  rlc_timer u_period (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .tmr_if   (period_if.tmr)
  );

  // ==========================================================
  // Read path
  assign eq_word    = {4'h0, field_eq};
  assign ctrl_word  = {status_reg, keep_eq_reg, debounce_reg,
                       detect_off_reg, period_reg, force_reg};
  assign rdata_next = !reg_read_in ? rdata_reg
                    : hit_eq       ? eq_word
                    : hit_ctrl     ? ctrl_word
                    : 8'h00;

  // ==========================================================
  // Output and status flops
  // One exit pulse per LFPS burst, re-armed when LFPS drops
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rdata_reg     <= 8'h00;
      status_reg    <= 1'b0;
      down_reg      <= 1'b0;
      up_reg        <= 1'b0;
      exit_done_reg <= 1'b0;
      up_eq_reg     <= 4'h0;
      first_eq_reg  <= 4'h0;
      second_eq_reg <= 4'h0;
    end
    else
    begin
      rdata_reg     <= rdata_next;
      status_reg    <= status_next;
      down_reg      <= down_next;
      up_reg        <= up_next;
      exit_done_reg <= lfps_sync_reg && (exit_done_reg || lfps_exit_now);
      up_eq_reg     <= zero_eq ? 4'h0 : field_eq;
      first_eq_reg  <= zero_eq ? 4'h0 : first_rx_eq_level_in;
      second_eq_reg <= zero_eq ? 4'h0 : second_rx_eq_level_in;
    end
  end

  assign reg_rdata_out             = rdata_reg;
  assign upstream_eq_applied_out   = up_eq_reg;
  assign first_eq_applied_out      = first_eq_reg;
  assign second_eq_applied_out     = second_eq_reg;
  assign low_power_exit_out        = lfps_exit_now;
  assign rx_detect_pulse_out       = period_if.expired;
  assign compliance_downstream_out = down_reg;
  assign compliance_upstream_out   = up_reg;

endmodule // rlc_link_ctrl

// >>> dv/rlc_host_model.sv
/*
  Host model of the configuration port: single byte writes and reads.
  Assumes one-cycle strobes and read data one cycle after the read edge.
*/
`timescale 1ns/1ps
module rlc_host_model
(
  input  wire logic       clk_in,
  input  wire logic [7:0] reg_rdata_in,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out,
  output logic            reg_write_out,
  output logic            reg_read_out
);
  // ==========================================================
  // Bus cycles
  initial
  begin
    reg_addr_out  = 8'h00;
    reg_wdata_out = 8'h00;
    reg_write_out = 1'b0;
    reg_read_out  = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_write_out <= 1'b1;
    @(posedge clk_in);
    reg_write_out <= 1'b0;
  endtask

  // Data is taken one edge after the read edge, where it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_read_out <= 1'b1;
    @(posedge clk_in);
    reg_read_out <= 1'b0;
    @(posedge clk_in);
    d = reg_rdata_in;
  endtask
endmodule // rlc_host_model

// >>> dv/rlc_link_ctrl_assertions.sv
/*
  Port checks of the link control bank.
  Assumes it is bound into rlc_link_ctrl on the same clock.
*/
`timescale 1ns/1ps
module rlc_link_ctrl_assertions
  import rlc_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_write_in,
  input wire logic       reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       lfps_detect_in,
  input wire logic       low_power_state_in,
  input wire logic       fsm_compliance_req_in,
  input wire logic [3:0] first_eq_applied_out,
  input wire logic [3:0] second_eq_applied_out,
  input wire logic       low_power_exit_out,
  input wire logic       rx_detect_pulse_out,
  input wire logic       compliance_downstream_out,
  input wire logic       compliance_upstream_out
);
  // ==========================================================
  // Shadow state
  logic [6:0] ctl_reg;
  logic [1:0] frc_reg;
  logic       fsm_reg;
  logic [1:0] sync_reg;
  wire        rd21 = reg_read_in && reg_addr_in == RLC_ADDR_UPSTREAM_EQ;
  wire        rd22 = reg_read_in && reg_addr_in == RLC_ADDR_LINK_CTRL;
  wire        wr22 = reg_write_in && reg_addr_in == RLC_ADDR_LINK_CTRL;
  wire        unmap = reg_read_in && !rd21 && !rd22;
  wire        any_cm = compliance_downstream_out | compliance_upstream_out;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ctl_reg  <= 7'h00;
      frc_reg  <= 2'h0;
      fsm_reg  <= 1'b0;
      sync_reg <= 2'h0;
    end
    else
    begin
      ctl_reg  <= wr22 ? reg_wdata_in[6:0] : ctl_reg;
      frc_reg  <= ctl_reg[1:0];
      fsm_reg  <= fsm_compliance_req_in;
      sync_reg <= {sync_reg[0], lfps_detect_in};
    end
  end

  // ==========================================================
  // Properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_down;
    compliance_downstream_out ==
      (frc_reg == 2'h1 || (frc_reg == 2'h0 && fsm_reg));
  endproperty
  a_down: assert property (p_down)
    else $error("downstream compliance wrong");
  property p_up;
    compliance_upstream_out ==
      (frc_reg == 2'h2 || (frc_reg == 2'h0 && fsm_reg));
  endproperty
  a_up: assert property (p_up)
    else $error("upstream compliance wrong");
  property p_rd22;
    rd22 |=> reg_rdata_out == {$past(any_cm), $past(ctl_reg)};
  endproperty
  a_rd22: assert property (p_rd22)
    else $error("control byte read wrong");
  property p_unmap;
    unmap |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_res21;
    rd21 |=> reg_rdata_out[7:4] == 4'h0;
  endproperty
  a_res21: assert property (p_res21)
    else $error("reserved bits not zero");
  // Three cycles let the synchroniser and output flop settle
  property p_eqzero;
    (sync_reg[1] && !ctl_reg[6])[*3] |->
      {first_eq_applied_out, second_eq_applied_out} == 8'h00;
  endproperty
  a_eqzero: assert property (p_eqzero)
    else $error("equalization not zeroed in lfps");
  property p_exit;
    $rose(sync_reg[1]) && low_power_state_in && !ctl_reg[5] |->
      low_power_exit_out;
  endproperty
  a_exit: assert property (p_exit)
    else $error("undebounced exit missing");
  property p_detect;
    (low_power_state_in && ctl_reg[4])[*3] |-> !rx_detect_pulse_out;
  endproperty
  a_detect: assert property (p_detect)
    else $error("detect pulse while disabled");
endmodule // rlc_link_ctrl_assertions

bind rlc_link_ctrl rlc_link_ctrl_assertions chk_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .lfps_detect_in(lfps_detect_in), .low_power_state_in(low_power_state_in),
  .fsm_compliance_req_in(fsm_compliance_req_in),
  .first_eq_applied_out(first_eq_applied_out),
  .second_eq_applied_out(second_eq_applied_out),
  .low_power_exit_out(low_power_exit_out),
  .rx_detect_pulse_out(rx_detect_pulse_out),
  .compliance_downstream_out(compliance_downstream_out),
  .compliance_upstream_out(compliance_upstream_out));

// >>> dv/redriver_link_control_regs_tb_top.sv
/*
  Self-checking bench of the link control bank.
  Assumes the host model drives the register port; short periods.
*/
`timescale 1ns/1ps
module redriver_link_control_regs_tb_top
  import rlc_pkg::*;
();
  localparam int PER_A = 20;
  localparam int PER_B = 30;
  logic       clk_in, rst_n_in, eq_src, lfps, lp, fsm;
  logic [1:0] straps, e;
  logic [3:0] rx1, rx2;
  logic [7:0] d, v;
  wire  [7:0] addr, wdata, rdata;
  wire  [3:0] up_eq, eq1, eq2;
  wire        wr, rd, ex_p, det_p, cm_dn, cm_up;
  int         err_total = 0;
  int         tests_run = 0;
  int         seed = 32'h046de667;
  int         n;

  rlc_host_model host_u (.clk_in(clk_in), .reg_rdata_in(rdata),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_write_out(wr),
    .reg_read_out(rd));
  rlc_link_ctrl #(.PERIOD_A_CYC(18'(PER_A)), .PERIOD_B_CYC(18'(PER_B)))
  dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .reg_rdata_out(rdata), .eq_source_software_in(eq_src),
    .upstream_eq_straps_in(straps), .first_rx_eq_level_in(rx1),
    .second_rx_eq_level_in(rx2), .lfps_detect_in(lfps),
    .low_power_state_in(lp), .fsm_compliance_req_in(fsm),
    .upstream_eq_applied_out(up_eq), .first_eq_applied_out(eq1),
    .second_eq_applied_out(eq2), .low_power_exit_out(ex_p),
    .rx_detect_pulse_out(det_p), .compliance_downstream_out(cm_dn),
    .compliance_upstream_out(cm_up));

  // ==========================================================
  // Helpers
  function automatic logic [1:0] cm_exp(input logic [1:0] c, input logic f);
    return {c == 2'h2 || (c == 2'h0 && f), c == 2'h1 || (c == 2'h0 && f)};
  endfunction

  task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
    tests_run++;
    if (g !== x)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask

  task automatic cnt_to(input bit ex, output int k);
    k = 0;
    do
    begin
      @(posedge clk_in);
      k++;
    end
    while ((ex ? ex_p : det_p) !== 1'b1 && k < 5000);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // Whole plan is near 4300 cycles
  initial
  begin
    #(50 * 20000);
    err_total++;
    results();
  end

  // ==========================================================
  // Tests
  initial
  begin
    {rst_n_in, eq_src, lfps, lp, fsm} = 5'h00;
    straps = 2'h2;
    {rx1, rx2} = 8'h96;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    host_u.rd(RLC_ADDR_UPSTREAM_EQ, v);
    chk("strap eq", {6'h00, straps}, v);
    host_u.rd(RLC_ADDR_LINK_CTRL, v);
    chk("ctrl reset", RLC_LINK_CTRL_RST, v);
    host_u.wr(RLC_ADDR_UPSTREAM_EQ, 8'hfa);
    eq_src <= 1'b1;
    host_u.rd(RLC_ADDR_UPSTREAM_EQ, v);
    chk("soft eq", 8'h0a, v);
    chk("eq applied", 8'h0a, {4'h0, up_eq});
    eq_src <= 1'b0;
    straps <= 2'h1;
    host_u.rd(RLC_ADDR_UPSTREAM_EQ, v);
    chk("strap again", 8'h02, v);
    host_u.wr(8'h23, 8'hff);
    host_u.rd(8'h23, v);
    chk("unmapped", 8'h00, v);
    $display("test register basics done");
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($random(seed));
      d[3] = 1'b0;
      d[1:0] = i[1:0];
      fsm <= 1'($random(seed));
      {rx1, rx2} <= 8'($random(seed));
      host_u.wr(RLC_ADDR_LINK_CTRL, d);
      host_u.rd(RLC_ADDR_LINK_CTRL, v);
      e = cm_exp(d[1:0], fsm);
      chk("ctrl byte", {|e, d[6:0]}, v);
      chk("compliance", {6'h00, e}, {6'h00, cm_up, cm_dn});
    end
    $display("test compliance codes done");
    fsm <= 1'b0;
    lp <= 1'b1;
    host_u.wr(RLC_ADDR_LINK_CTRL, 8'h10);
    repeat (3) @(posedge clk_in);
    n = 0;
    repeat (70)
    begin
      @(posedge clk_in);
      n += int'(det_p === 1'b1);
    end
    chk("detect off", 8'h00, 8'(n));
    for (int p = 0; p < 2; p++)
    begin
      host_u.wr(RLC_ADDR_LINK_CTRL, 8'(p << 2));
      cnt_to(1'b0, n);
      cnt_to(1'b0, n);
      chk("detect period", 8'(p ? PER_B : PER_A), 8'(n));
    end
    $display("test detect timing done");
    lfps <= 1'b1;
    cnt_to(1'b1, n);
    chk("fast exit", 8'h03, 8'(n));
    repeat (3) @(posedge clk_in);
    chk("keep_eq_during_lfps zero", 8'h00, {eq1, eq2});
    host_u.wr(RLC_ADDR_LINK_CTRL, 8'h40);
    repeat (2) @(posedge clk_in);
    chk("keep_eq_during_lfps kept", {rx1, rx2}, {eq1, eq2});
    lfps <= 1'b0;
    host_u.wr(RLC_ADDR_LINK_CTRL, 8'h20);
    repeat (4) @(posedge clk_in);
    lfps <= 1'b1;
    cnt_to(1'b1, n);
    chk("slow exit", 8'h01, 8'(n >= 4000 && n <= 4004));
    $display("test lfps handling done");
    results();
  end
endmodule // redriver_link_control_regs_tb_top
